//--- hw/sabi_top.sv
`timescale 1ns/1ps
module sabi_top
    import sabi_pkg::*;
(
    input  wire logic             clock,              // 40 MHz clock
    input  wire logic             sys_rst,            // synchronous reset, high
    input  wire logic             cs_n,               // chip select, low
    input  wire logic             wr_n,               // write strobe, low
    input  wire logic             rd_n,               // read strobe, low
    input  wire logic             cmp_pos_above,      // comparator: pos input above trial level
    input  wire logic             neg_at_or_above,    // negative input >= positive input
    output logic      [RES_W-1:0] trial_code,         // dac trial code to analog side
    output logic      [RES_W-1:0] result_bus_o,       // result_bus output data
    output logic      [RES_W-1:0] result_bus_oe,      // result_bus drive enable
    output logic                  conversion_done_n   // result ready, low
);
    sabi_state_t      state_ff,   nxt_state;
    logic [RES_W-1:0] sar_ff,     nxt_sar;
    logic [2:0]       bit_ff,     nxt_bit;
    logic [STEP_W-1:0] step_ff,   nxt_step;
    logic             done_n_ff,  nxt_done_n;
    logic             wr_n_ff;
    logic             diff_neg_ff;
    logic [RES_W-1:0] latched;
    logic [RES_W-1:0] bus_ff;
    logic             oe_ff;

    // distance of a bit position from the top bit, used for trial and keep masks
    function automatic logic [2:0] bit_dist(input logic [2:0] b);
        bit_dist = BIT_FIRST - b;
    endfunction

    // pacing: STEP_CYC clocks per compare; eight compares keep the whole
    // conversion inside the limit with room left for the sample cycle
    wire wr_sel   = ~cs_n & ~wr_n;
    wire wr_fall  = wr_sel & wr_n_ff;
    wire wr_rise  = ~cs_n & wr_n & ~wr_n_ff;
    wire rd_sel   = ~cs_n & ~rd_n;
    wire step_end = (step_ff == STEP_W'(STEP_CYC - 1));
    wire last_bit = (bit_ff == BIT_LAST);
    // keep or drop the current trial bit based on the comparator
    wire [RES_W-1:0] kept   = cmp_pos_above ? sar_ff : (sar_ff & ~(MSB_TRIAL >> bit_dist(bit_ff)));
    wire [RES_W-1:0] next_t = kept | (MSB_TRIAL >> (bit_dist(bit_ff) + 3'h1));
    wire [RES_W-1:0] final_code = diff_neg_ff ? ZERO_CODE : kept;
    // high for the whole conversion, used by the finish strobe
    wire             in_conv = (state_ff == SABI_CONV);
    wire             finish = in_conv & step_end & last_bit;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_sar   = sar_ff;
        nxt_bit   = bit_ff;
        nxt_step  = step_ff;
        case (state_ff)
            SABI_IDLE, SABI_DONE:
            begin
                if (wr_fall)
                begin
                    nxt_state = SABI_ARMED;
                end
            end
            SABI_ARMED:
            begin
                // a rise with no fall before it never reaches this state
                if (wr_rise)
                begin
                    nxt_state = SABI_CONV;
                    nxt_sar   = MSB_TRIAL;
                    nxt_bit   = BIT_FIRST;
                    nxt_step  = '0;
                end
            end
            SABI_CONV:
            begin
                // a new write restarts the conversion
                if (wr_fall)
                begin
                    nxt_state = SABI_ARMED;
                end
                else if (step_end)
                begin
                    nxt_step = '0;
                    if (last_bit)
                    begin
                        nxt_sar   = final_code;
                        nxt_state = SABI_DONE;
                    end
                    else
                    begin
                        nxt_sar = next_t;
                        nxt_bit = bit_ff - 3'h1;
                    end
                end
                else
                begin
                    nxt_step = step_ff + STEP_W'(1);
                end
            end
            default:
            begin
                nxt_state = SABI_IDLE;
            end
        endcase
    end

    // done line: set on completion, cleared by either strobe; a completion in
    // the same cycle as a strobe wins, so a finished result is never hidden
    always_comb
    begin
        nxt_done_n = done_n_ff;
        if (wr_fall | rd_sel)
        begin
            nxt_done_n = 1'b1;
        end
        if (finish)
        begin
            nxt_done_n = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_ff <= SABI_IDLE;
            step_ff  <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            step_ff  <= nxt_step;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sar_ff <= ZERO_CODE;
            bit_ff <= BIT_FIRST;
        end
        else
        begin
            sar_ff <= nxt_sar;
            bit_ff <= nxt_bit;
        end
    end

    // write strobe history idles high, so leaving reset never looks like a rise
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            done_n_ff <= 1'b1;
            wr_n_ff   <= 1'b1;
        end
        else
        begin
            done_n_ff <= nxt_done_n;
            wr_n_ff   <= wr_n;
        end
    end

    // sample the input polarity at conversion start
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            diff_neg_ff <= 1'b0;
        end
        else if (wr_rise)
        begin
            diff_neg_ff <= neg_at_or_above;
        end
    end

    sabi_result_latch u_latch (
        .clock   (clock),
        .sys_rst (sys_rst),
        .load    (finish),
        .din     (final_code),
        .dout    (latched)
    );

    // data and enable registered: drive one cycle after rd select, drop one
    // after release; the extra cycle is traded for glitch-free bus outputs
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            bus_ff <= ZERO_CODE;
        end
        else
        begin
            bus_ff <= latched;
        end
    end

    // enable follows the read select only, so the bus is released between reads
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            oe_ff <= 1'b0;
        end
        else
        begin
            oe_ff <= rd_sel;
        end
    end

    assign trial_code        = sar_ff;
    assign result_bus_o      = bus_ff;
    assign result_bus_oe     = {RES_W{oe_ff}};
    assign conversion_done_n = done_n_ff;
endmodule

//--- hw/sabi_pkg.sv
package sabi_pkg;
    localparam int          RES_W          = 8;
    localparam int          CLK_MHZ        = 40;
    // longest conversion time, in nanoseconds
    localparam int          CONV_MAX_NS    = 60000;
    localparam int          CLK_PERIOD_NS  = 1000 / CLK_MHZ;
    // longest time rounds down
    localparam int          CONV_CYC       = CONV_MAX_NS / CLK_PERIOD_NS;
    // one compare step per bit plus two spare steps; must fit within CONV_CYC
    localparam int          STEP_CYC       = CONV_CYC / (RES_W + 2);
    localparam int          STEP_W         = $clog2(STEP_CYC + 1);
    localparam logic [RES_W-1:0] ZERO_CODE = 8'h00;
    localparam logic [RES_W-1:0] MSB_TRIAL = 8'h80;
    localparam logic [2:0]  BIT_LAST       = 3'h0;
    localparam logic [2:0]  BIT_FIRST      = 3'h7;
    localparam logic [RES_W-1:0] RESULT_RST = 8'h00;
    typedef enum logic [1:0] {SABI_IDLE, SABI_ARMED, SABI_CONV, SABI_DONE} sabi_state_t;
endpackage

//--- hw/sabi_result_latch.sv
`timescale 1ns/1ps
// output latch: holds the last result until a new one is loaded
module sabi_result_latch
    import sabi_pkg::*;
(
    input  wire logic             clock,    // system clock
    input  wire logic             sys_rst,  // synchronous reset
    input  wire logic             load,     // take new result
    input  wire logic [RES_W-1:0] din,      // new result
    output logic      [RES_W-1:0] dout      // latched result
);
    logic [RES_W-1:0] store_ff;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            store_ff <= RESULT_RST;
        else if (load)
            store_ff <= din;
    end

    assign dout = store_ff;
endmodule

//--- bench/sabi_props.sv
`timescale 1ns/1ps
module sabi_props (
    input wire logic       clock, sys_rst, cs_n, wr_n, rd_n,
    input wire logic       neg_at_or_above, conversion_done_n,
    input wire logic [7:0] result_bus_o, result_bus_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire rd = !cs_n && !rd_n;
    wire done = !conversion_done_n;
    logic        wr_n_q;
    logic [11:0] conv_cnt;
    // counts clocks from the write rise until the done line falls
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            wr_n_q   <= 1'b1;
            conv_cnt <= 12'h000;
        end
        else
        begin
            wr_n_q <= wr_n;
            if (!cs_n && wr_n && !wr_n_q)
                conv_cnt <= 12'h001;
            else if (done)
                conv_cnt <= 12'h000;
            else if (conv_cnt != 12'h000)
                conv_cnt <= conv_cnt + 12'h001;
        end
    end
    a_read_drives: assert property (rd |=> result_bus_oe == 8'hFF) else $error("no drive");
    a_read_clears: assert property (rd && done |=> !done) else $error("rd no clr");
    a_bus_release: assert property (cs_n || rd_n |=> result_bus_oe == 8'h00) else $error("oe");
    a_write_clears: assert property (!cs_n && !wr_n && $past(wr_n) |=> !done) else $error("wr");
    a_done_holds: assert property (done && (cs_n || wr_n && rd_n) |=> done) else $error("hold");
    a_conv_bound: assert property (conv_cnt <= 12'h960) else $error("slow");
    a_latch_hold: assert property ($changed(result_bus_o) |-> ##[0:1] done) else $error("lat");
    a_zero_code: assert property ($rose(done) && neg_at_or_above |=> result_bus_o == 8'h00)
        else $error("zero");
    c_read: cover property (rd && done);
    c_done: cover property ($rose(done));
    c_zero: cover property ($rose(done) && neg_at_or_above);
endmodule
bind sabi_top sabi_props u_props (.clock(clock), .sys_rst(sys_rst), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .neg_at_or_above(neg_at_or_above), .conversion_done_n(conversion_done_n),
    .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe));

//--- bench/sabi_far_model.sv
`timescale 1ns/1ps
module sabi_far_model (
    input  wire logic       clock,
    input  wire logic [7:0] vin_code, trial_code, result_bus_o, result_bus_oe,
    output logic            cmp_pos_above,
    output logic [7:0]      result_bus
);
    logic [7:0] last_ff;
    // input sits half a step above vin_code, so an equal trial still counts as above
    assign cmp_pos_above = vin_code >= trial_code;
    // a released bus must not look like a held copy of the result
    assign result_bus = (result_bus_oe == 8'hFF) ? result_bus_o : ~last_ff;
    always_ff @(posedge clock)
    begin
        if (result_bus_oe == 8'hFF)
            last_ff <= result_bus_o;
    end
endmodule

//--- bench/sar_adc_bus_interface_bench.sv
`timescale 1ns/1ps
module sar_adc_bus_interface_bench;
    logic       clock = 0, sys_rst = 1, cs_n = 1, wr_n = 1, rd_n = 1, neg_at_or_above = 0;
    logic [7:0] vin_code = 8'h00, trial_code, result_bus_o, result_bus_oe, result_bus;
    logic       cmp_pos_above, conversion_done_n, was_on = 0;
    logic [7:0] exp_q[$];
    int         mismatches = 0, checked = 0, cycles = 0;
    always #12.5 clock = ~clock;
    sabi_top dut (.clock(clock), .sys_rst(sys_rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .cmp_pos_above(cmp_pos_above), .neg_at_or_above(neg_at_or_above),
        .trial_code(trial_code), .result_bus_o(result_bus_o),
        .result_bus_oe(result_bus_oe), .conversion_done_n(conversion_done_n));
    sabi_far_model far (.clock(clock), .vin_code(vin_code), .trial_code(trial_code),
        .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe),
        .cmp_pos_above(cmp_pos_above), .result_bus(result_bus));
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr_pulse;
        @(negedge clock) {cs_n, wr_n} = 2'b00;
        repeat (2) @(negedge clock);
        chk("done_n after write", {7'h0, conversion_done_n}, 8'h01);
        wr_n = 1;
        @(negedge clock) cs_n = 1;
    endtask
    task automatic rd_cycle(logic [7:0] exp);
        exp_q.push_back(exp);
        @(negedge clock) {cs_n, rd_n} = 2'b00;
        repeat (2) @(negedge clock);
        chk("done_n after read", {7'h0, conversion_done_n}, 8'h01);
        {cs_n, rd_n} = 2'b11;
        repeat (2) @(negedge clock);
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles > 30000)
        begin
            mismatches++;
            complete_run();
        end
        if (result_bus_oe === 8'hFF && !was_on)
            chk("result_bus", result_bus, exp_q.pop_front());
        was_on = (result_bus_oe === 8'hFF);
    end
    initial
    begin
        logic [7:0] v;
        int         w;
        void'($urandom(32'hc869afe0));
        repeat (8) @(negedge clock);
        sys_rst = 0;
        for (int i = 0; i < 8; i++)
        begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            neg_at_or_above = (i % 3 == 2);
            // a second write mid-conversion restarts it on the new input
            vin_code = (i == 4) ? ~v : v;
            wr_pulse();
            if (i == 4)
            begin
                repeat (100) @(negedge clock);
                vin_code = v;
                wr_pulse();
            end
            w = 0;
            while (conversion_done_n !== 1'b0 && w < 2400)
            begin
                @(negedge clock);
                w++;
            end
            chk("conversion in time", {7'h0, w < 2400}, 8'h01);
            repeat (5) @(negedge clock);
            chk("done_n held", {7'h0, conversion_done_n}, 8'h00);
            v = neg_at_or_above ? 8'h00 : v;
            rd_cycle(v);
            rd_cycle(v);
        end
        complete_run();
    end
endmodule
